// ### include/vdip_pkg.sv
// Package with the register map, field positions and reset values.
package vdip_pkg;
   localparam int VDIP_BASE_BITS = 13;
   localparam int VDIP_PORT_COUNT = 8;
   localparam int VDIP_CHANNELS = 64;
   localparam int VDIP_PATTERN_BITS = 16;
   // Offsets inside the input port block.
   localparam logic [2:0] VDIP_PORTS_LO_OFF = 3'h0;
   localparam logic [2:0] VDIP_PORTS_HI_OFF = 3'h4;
   // Offsets inside the control block.
   localparam logic [2:0] VDIP_CSR_OFF = 3'h0;
   localparam logic [2:0] VDIP_TEST_PAT_OFF = 3'h4;
   // Field positions in control_status_reg.
   localparam int VDIP_CSR_TEST_BIT = 0;
   localparam int VDIP_CSR_FAIL_BIT = 1;
   localparam int VDIP_CSR_HIDEF_BIT = 2;
   // Reset values.
   localparam logic VDIP_TEST_RST = 1'b0;
   localparam logic VDIP_FAIL_RST = 1'b1;
   localparam logic [15:0] VDIP_TEST_PAT_RST = 16'h0000;

   // True when an A16 word address falls into the 8-byte block at base.
   function automatic logic vdip_base_match(input logic [15:0] a16,
                                             input logic [12:0] base);
      return a16[15:3] == base;
   endfunction
endpackage

// ### logic/vdip_top.sv
// APB slave for a 64-channel digital input board with built-in test.
// Operation
// - Sixty-four inputs read as eight byte ports.
// - Only short I/O space, configured privilege accepted.
// - Ports read four to an aligned word; unaligned refused.
// - One-byte control register at its own base.
// - Thirteen static inputs set each block's decode base.
// - Open channel reads zero, or one if selected.
// - Software writes a held 16-bit test pattern.
// - Test mode feeds pattern into the receivers.
// - Fail indicator lit at power-up until cleared.
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
module vdip_top
   import vdip_pkg::*;
#(
   parameter int BASE_BITS = VDIP_BASE_BITS,
   parameter int CHANNELS = VDIP_CHANNELS
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [2:0] pprot,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [12:0] port_base_sel,
   input wire logic [12:0] ctrl_base_sel,
   input wire logic accept_supervisory,
   input wire logic accept_nonprivileged,
   input wire logic open_reads_high,
   input wire logic [63:0] field_in,
   input wire logic [63:0] field_open,
   output logic test_mode,
   output logic fail_led
);

   // Only the documented geometry is wired; other sizes are refused.
   if (BASE_BITS != VDIP_BASE_BITS) begin
      $error("vdip_top supports only 13 base address bits");
   end
   if (CHANNELS != VDIP_CHANNELS) begin
      $error("vdip_top supports only 64 channels");
   end
   if (CHANNELS != VDIP_PORT_COUNT * 8) begin
      $error("vdip_top needs eight byte ports over its channels");
   end
   if (CHANNELS != 4 * VDIP_PATTERN_BITS) begin
      $error("vdip_top needs four pattern copies over its channels");
   end
   if (BASE_BITS + 3 != 16) begin
      $error("vdip_top decodes an eight-byte block of a 16-bit space");
   end
   // Two registers at one offset would shadow each other silently.
   if (VDIP_PORTS_LO_OFF == VDIP_PORTS_HI_OFF) begin
      $error("vdip_top port block offsets overlap");
   end
   if (VDIP_CSR_OFF == VDIP_TEST_PAT_OFF) begin
      $error("vdip_top control block offsets overlap");
   end

   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic test_mode_r;
   logic fail_r;
   logic [15:0] test_pat_r;

   // Keeps the old byte unless its write strobe is set.
   function automatic logic [7:0] lane_merge(input logic strobe,
                                             input logic [7:0] new_byte,
                                             input logic [7:0] old_byte);
      return strobe ? new_byte : old_byte;
   endfunction

   // An open channel shows the board's default level, not the field.
   function automatic logic [7:0] port_level(input logic [7:0] lvl,
                                             input logic [7:0] opn,
                                             input logic high_default);
      return (lvl & ~opn) | ({8{high_default}} & opn);
   endfunction

   // Picks byte port n out of the 64 receiver levels.
   function automatic logic [7:0] port_byte(input logic [63:0] rx,
                                            input int n);
      return rx[n * 8 +: 8];
   endfunction

   // Builds the control byte from the field positions of the package.
   function automatic logic [7:0] csr_pack(input logic test,
                                           input logic fail,
                                           input logic hidef);
      logic [7:0] b;
      b = 8'h00;
      b[VDIP_CSR_TEST_BIT] = test;
      b[VDIP_CSR_FAIL_BIT] = fail;
      b[VDIP_CSR_HIDEF_BIT] = hidef;
      return b;
   endfunction

   // Short space: the upper address half must be zero, words aligned.
   wire logic [15:0] a16 = paddr[15:0];
   wire logic upper_zero = (paddr[31:16] == 16'h0000);
   wire logic word_aligned = (paddr[1:0] == 2'h0);
   wire logic short_space = upper_zero && word_aligned;
   // Privileged accesses are taken as supervisory ones.
   wire logic is_supervisory = pprot[0];
   wire logic am_ok = is_supervisory ? accept_supervisory
                                     : accept_nonprivileged;
   wire logic base_ok = short_space && am_ok;

   // Each block compares the thirteen upper address bits to its base.
   wire logic port_base_hit = vdip_base_match(a16, port_base_sel);
   wire logic ctrl_base_hit = vdip_base_match(a16, ctrl_base_sel);
   wire logic port_hit = base_ok && port_base_hit;
   // The ports win when both bases are jumpered to the same block.
   wire logic ctrl_hit = base_ok && !port_hit && ctrl_base_hit;

   // Offset inside the selected eight-byte block.
   wire logic [2:0] offset = a16[2:0];
   wire logic sel_hi = (offset == VDIP_PORTS_HI_OFF);
   wire logic csr_sel = ctrl_hit && (offset == VDIP_CSR_OFF);
   wire logic pat_sel = ctrl_hit && (offset == VDIP_TEST_PAT_OFF);
   wire logic hit = port_hit || csr_sel || pat_sel;

   // Receiver inputs: the field, or the open-circuit default level.
   wire logic [7:0] field_p0 = port_level(
      port_byte(field_in, 0),
      port_byte(field_open, 0),
      open_reads_high);
   wire logic [7:0] field_p1 = port_level(
      port_byte(field_in, 1),
      port_byte(field_open, 1),
      open_reads_high);
   wire logic [7:0] field_p2 = port_level(
      port_byte(field_in, 2),
      port_byte(field_open, 2),
      open_reads_high);
   wire logic [7:0] field_p3 = port_level(
      port_byte(field_in, 3),
      port_byte(field_open, 3),
      open_reads_high);
   wire logic [7:0] field_p4 = port_level(
      port_byte(field_in, 4),
      port_byte(field_open, 4),
      open_reads_high);
   wire logic [7:0] field_p5 = port_level(
      port_byte(field_in, 5),
      port_byte(field_open, 5),
      open_reads_high);
   wire logic [7:0] field_p6 = port_level(
      port_byte(field_in, 6),
      port_byte(field_open, 6),
      open_reads_high);
   wire logic [7:0] field_p7 = port_level(
      port_byte(field_in, 7),
      port_byte(field_open, 7),
      open_reads_high);

   // In test mode the pattern replaces every quarter of the field.
   wire logic [63:0] test_rx = {4{test_pat_r}};
   wire logic [7:0] test_p0 = port_byte(test_rx, 0);
   wire logic [7:0] test_p1 = port_byte(test_rx, 1);
   wire logic [7:0] test_p2 = port_byte(test_rx, 2);
   wire logic [7:0] test_p3 = port_byte(test_rx, 3);
   wire logic [7:0] test_p4 = port_byte(test_rx, 4);
   wire logic [7:0] test_p5 = port_byte(test_rx, 5);
   wire logic [7:0] test_p6 = port_byte(test_rx, 6);
   wire logic [7:0] test_p7 = port_byte(test_rx, 7);

   // Test mode also overrides the open-circuit default of a channel.
   wire logic [7:0] rx_p0 = test_mode_r ? test_p0 : field_p0;
   wire logic [7:0] rx_p1 = test_mode_r ? test_p1 : field_p1;
   wire logic [7:0] rx_p2 = test_mode_r ? test_p2 : field_p2;
   wire logic [7:0] rx_p3 = test_mode_r ? test_p3 : field_p3;
   wire logic [7:0] rx_p4 = test_mode_r ? test_p4 : field_p4;
   wire logic [7:0] rx_p5 = test_mode_r ? test_p5 : field_p5;
   wire logic [7:0] rx_p6 = test_mode_r ? test_p6 : field_p6;
   wire logic [7:0] rx_p7 = test_mode_r ? test_p7 : field_p7;
   wire logic [63:0] receivers = {rx_p7, rx_p6, rx_p5, rx_p4,
                                  rx_p3, rx_p2, rx_p1, rx_p0};

   // Port n sits in byte lane n mod 4 of its word; only word-aligned reads are
   // taken, so each read returns an aligned group of four ports.
   wire logic [7:0] port_0 = port_byte(receivers, 0);
   wire logic [7:0] port_1 = port_byte(receivers, 1);
   wire logic [7:0] port_2 = port_byte(receivers, 2);
   wire logic [7:0] port_3 = port_byte(receivers, 3);
   wire logic [7:0] port_4 = port_byte(receivers, 4);
   wire logic [7:0] port_5 = port_byte(receivers, 5);
   wire logic [7:0] port_6 = port_byte(receivers, 6);
   wire logic [7:0] port_7 = port_byte(receivers, 7);
   wire logic [31:0] ports_lo = {port_3, port_2, port_1, port_0};
   wire logic [31:0] ports_hi = {port_7, port_6, port_5, port_4};
   wire logic [31:0] port_word = sel_hi ? ports_hi
                                        : ports_lo;

   // The control block answers with zero-padded narrow registers.
   wire logic [7:0] csr_byte = csr_pack(test_mode_r, fail_r,
                                        open_reads_high);
   wire logic [31:0] csr_data = {24'h000000, csr_byte};
   wire logic [31:0] pat_data = {16'h0000, test_pat_r};
   wire logic [31:0] read_mux = port_hit ? port_word :
                                csr_sel ? csr_data :
                                pat_sel ? pat_data :
                                32'h00000000;

   // A write commits at the edge where the master sees pready high.
   wire logic access = psel && penable;
   wire logic commit = access && pready_r && pwrite;
   wire logic csr_wr = commit && csr_sel && pstrb[0];
   wire logic pat_wr_lo = commit && pat_sel && pstrb[0];
   wire logic pat_wr_hi = commit && pat_sel && pstrb[1];

   // Byte lanes of the write data as the registers take them.
   wire logic [7:0] wr_byte0 = pwdata[7:0];
   wire logic [7:0] wr_byte1 = pwdata[15:8];
   wire logic csr_test_in = wr_byte0[VDIP_CSR_TEST_BIT];
   wire logic csr_fail_in = wr_byte0[VDIP_CSR_FAIL_BIT];

   // Next values: each register holds unless its own write lands.
   wire logic test_mode_nxt = csr_wr ? csr_test_in
                                     : test_mode_r;
   wire logic fail_nxt = csr_wr ? csr_fail_in
                                : fail_r;
   wire logic [7:0] pat_lo_nxt = lane_merge(pat_wr_lo, wr_byte0,
                                            test_pat_r[7:0]);
   wire logic [7:0] pat_hi_nxt = lane_merge(pat_wr_hi, wr_byte1,
                                            test_pat_r[15:8]);
   wire logic [15:0] test_pat_nxt = {pat_hi_nxt, pat_lo_nxt};

   // One wait state: pready rises in the second access cycle.
   wire logic pready_nxt = access && !pready_r;
   wire logic pslverr_nxt = access && !pready_r && !hit;
   wire logic [31:0] prdata_nxt = (access && !pready_r && !pwrite)
                                  ? read_mux : 32'h00000000;

   // Answer flops: every bus output leaves straight from a register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
      end else begin
         pready_r <= pready_nxt;
      end
   end

   // Refusal is reported in the same cycle as the answer.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_r <= 1'b0;
      end else begin
         pslverr_r <= pslverr_nxt;
      end
   end

   // Read data is zero outside its one answer cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h00000000;
      end else begin
         prdata_r <= prdata_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         test_mode_r <= VDIP_TEST_RST;
      end else begin
         test_mode_r <= test_mode_nxt;
      end
   end

   // The fail lamp comes up lit from reset so a dead board shows.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fail_r <= VDIP_FAIL_RST;
      end else begin
         fail_r <= fail_nxt;
      end
   end

   // The pattern survives test mode changes; only a write moves it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         test_pat_r <= VDIP_TEST_PAT_RST;
      end else begin
         test_pat_r <= test_pat_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign test_mode = test_mode_r;
   assign fail_led = fail_r;
endmodule

// ### dv/vdip_field.sv
// Field side model: receiver levels and open-circuit flags.
module vdip_field (
   input wire logic [63:0] lvl,
   input wire logic [63:0] opn,
   output logic [63:0] field_in,
   output logic [63:0] field_open
);
   timeunit 1ns;
   timeprecision 1ps;
   // An open input floats, so it shows the inverse of the driven level.
   assign field_in = (lvl & ~opn) | (~lvl & opn);
   assign field_open = opn;
endmodule

// ### dv/vdip_top_chk.sv
// Checker of bus timing and lamp and mode state of vdip_top.
module vdip_top_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic test_mode,
   input wire logic fail_led
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_acc;
      psel && !penable ##1 psel && penable;
   endsequence
   a_one_wait: assert property (s_acc |=> pready) else $error("late");
   a_ready_pulse: assert property (pready |=> !pready) else $error("long");
   a_ready_cause: assert property (pready |-> $past(psel && penable))
      else $error("stray answer");
   a_high_err: assert property (pready && paddr[31:16] != 0 |-> pslverr)
      else $error("high address taken");
   a_align_err: assert property (pready && paddr[1:0] != 0 |-> pslverr)
      else $error("misaligned taken");
   a_err_data: assert property (pready && pslverr |-> prdata == 0)
      else $error("refused data");
   a_idle_quiet: assert property (!pready |-> prdata == 0 && !pslverr)
      else $error("idle outputs");
   a_state_hold: assert property (!(pready && pwrite && !pslverr)
      |=> $stable({test_mode, fail_led})) else $error("state moved");
endmodule
bind vdip_top vdip_top_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .prdata, .pready, .pslverr, .test_mode, .fail_led);

// ### dv/tb.sv
// Self-checking bench for vdip_top.
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
   num_errors++; $display("Error %s exp %0h got %0h", n, e, s); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
   logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
   logic [2:0] pprot = 3'h1;
   logic [63:0] lvl = 64'h0123456789ABCDEF, opn = 64'hFF0000F0, fin, fop;
   logic pready, pslverr, test_mode, fail_led, ohigh = 0;
   int num_errors = 0, checks_done = 0;
   always #4 pclk = ~pclk;
   vdip_field fld_u (.lvl, .opn, .field_in(fin), .field_open(fop));
   vdip_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb(4'hF), .pprot, .prdata, .pready, .pslverr,
      .port_base_sel(13'h0010), .ctrl_base_sel(13'h0020),
      .accept_supervisory(1'b1), .accept_nonprivileged(1'b0),
      .open_reads_high(ohigh), .field_in(fin), .field_open(fop),
      .test_mode, .fail_led);
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      {rd, er} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask
   task t_ports;
      apb(0, 32'h80, 0);
      `CHK("ports lo", lvl[31:0] & ~opn[31:0], rd)
      apb(0, 32'h84, 0);
      `CHK("ports hi", lvl[63:32] & ~opn[63:32], rd)
   endtask
   task t_refuse;
      apb(0, 32'h88, 0);
      `CHK("unmatched", 33'h0_0000_0001, {rd, er})
      pprot <= 3'h0;
      apb(0, 32'h80, 0);
      `CHK("user access", 1'b1, er)
      pprot <= 3'h1;
      apb(0, 32'h82, 0);
      `CHK("misaligned", 33'h0_0000_0001, {rd, er})
      apb(1, 32'h10100, 0);
      `CHK("lamp kept", 1'b1, fail_led)
   endtask
   task t_open;
      ohigh <= 1'b1;
      apb(0, 32'h80, 0);
      `CHK("open high", lvl[31:0] | opn[31:0], rd)
      apb(0, 32'h100, 0);
      `CHK("option bit", 8'h06, rd[7:0])
      ohigh <= 1'b0;
   endtask
   task t_bist;
      apb(1, 32'h104, 32'hA5C3);
      apb(1, 32'h100, 32'h1);
      #1 `CHK("mode and lamp", 2'b10, {test_mode, fail_led})
      apb(0, 32'h84, 0);
      `CHK("pattern in", 32'hA5C3A5C3, rd)
      apb(0, 32'h100, 0);
      `CHK("control", 8'h01, rd[7:0])
      apb(0, 32'h104, 0);
      `CHK("pattern kept", 16'hA5C3, rd[15:0])
   endtask
   task print_verdict;
      if (num_errors == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      `CHK("lamp at reset", 2'b01, {test_mode, fail_led})
      t_ports;
      t_refuse;
      t_open;
      t_bist;
      print_verdict;
   end
   // The whole run is about sixty cycles, so this leaves a wide margin.
   initial begin
      #40000;
      num_errors++;
      print_verdict;
   end
endmodule
